// ==== inc/svc_pkg.sv ====
// Package with the register map, field layout and reset values of the bank.
package svc_pkg;

  // Byte offsets of the five dwords.
  localparam logic [7:0]  SVC_OFF_CAP       = 8'h64;
  localparam logic [7:0]  SVC_OFF_SCR0      = 8'h68;
  localparam logic [7:0]  SVC_OFF_SCR1      = 8'h6c;
  localparam logic [7:0]  SVC_OFF_TIMER     = 8'h70;
  localparam logic [7:0]  SVC_OFF_MODE      = 8'h74;

  // Capability header constants.
  localparam logic [7:0]  SVC_CAP_ID        = 8'h09;
  localparam logic [7:0]  SVC_CAP_NEXT      = 8'hb0;
  localparam logic [15:0] SVC_CAP_LEN       = 16'h0034;

  // Scratch reset values.
  localparam logic [31:0] SVC_SCR0_RST      = 32'h0400_1060;
  localparam logic [31:0] SVC_SCR1_RST      = 32'h0000_0800;

  // Timer register field layout.
  localparam int          SVC_RPL_LSB       = 0;
  localparam int          SVC_RPL_W         = 12;
  localparam int          SVC_RPL_EN_BIT    = 12;
  localparam int          SVC_PM_DIS_BIT    = 13;
  localparam int          SVC_MSI_DIS_BIT   = 14;
  localparam int          SVC_ACK_LSB       = 16;
  localparam int          SVC_ACK_W         = 14;
  localparam int          SVC_ACK_EN_BIT    = 30;
  localparam int          SVC_VGA_BIT       = 31;
  localparam logic [31:0] SVC_TIMER_RST     = 32'h0000_0000;
  localparam logic [31:0] SVC_TIMER_SW_MASK = 32'h7fff_1fff;
  localparam logic [31:0] SVC_TIMER_LD_MASK = 32'h7fff_7fff;
  localparam logic        SVC_VGA_RST       = 1'b1;

  // Mode register field layout.
  localparam int          SVC_SF_BIT        = 0;
  localparam int          SVC_CT_LSB        = 1;
  localparam int          SVC_ARB_BIT       = 3;
  localparam int          SVC_CREDIT_BIT    = 4;
  localparam int          SVC_EGRESS_BIT    = 5;
  localparam logic [31:0] SVC_MODE_RST      = 32'h0000_0002;
  localparam logic [31:0] SVC_MODE_MASK     = 32'h0000_003f;

  // Link width codes seen by the built-in timer tables.
  typedef enum logic [1:0] {SVC_W_X1, SVC_W_X2, SVC_W_X4, SVC_W_RSVD}
    svc_width_e;

endpackage

// ==== rtl/svc_link_timers.sv ====
// Effective replay timeout and acknowledge latency selection.
`timescale 1ns/1ns
module svc_link_timers
  import svc_pkg::*;
#(
  parameter int RPL_BASE = 256,
  parameter int RPL_STEP = 128,
  parameter int ACK_BASE = 64,
  parameter int ACK_STEP = 32
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire svc_pkg::svc_width_e  link_width,
  input  wire logic [2:0]           max_payload,
  input  wire logic                 rpl_user_en,
  input  wire logic [11:0]          rpl_user,
  input  wire logic                 ack_user_en,
  input  wire logic [13:0]          ack_user,
  output logic [11:0]               replay_timeout,
  output logic [13:0]               ack_latency
);

  // Built-in value grows with payload size and shrinks with wider links.
  function automatic logic [15:0] builtin(input int base, input int step,
                                          input svc_width_e w,
                                          input logic [2:0] pl);
    logic [15:0] raw;
    raw = 16'(base + step * int'(pl));
    builtin = raw >> w;
  endfunction

  logic [15:0] rpl_builtin;
  logic [15:0] ack_builtin;

  // Table lookups, reserved code shifted one step past the widest link.
  always_comb
  begin
    rpl_builtin = builtin(RPL_BASE, RPL_STEP, link_width, max_payload);
    ack_builtin = builtin(ACK_BASE, ACK_STEP, link_width, max_payload);
  end

  // Replay timeout register: user value only while its enable is set.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      replay_timeout <= 12'h000;
    else if (rpl_user_en)
      replay_timeout <= rpl_user;
    else
      replay_timeout <= rpl_builtin[11:0];
  end

  // Acknowledge latency register: user value only while its enable is set.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_latency <= 14'h0000;
    else if (ack_user_en)
      ack_latency <= ack_user;
    else
      ack_latency <= ack_builtin[13:0];
  end

endmodule

// ==== rtl/svc_rr_arb.sv ====
// Round-robin port arbiter with credit-aware or sticky policy.
`timescale 1ns/1ns
module svc_rr_arb #(
  parameter int N = 3
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         stay,
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] credit_ok,
  output logic [N-1:0]      grant
);

  localparam int IW = (N > 1) ? $clog2(N) : 1;

  logic [IW-1:0] cur;
  logic [IW-1:0] next_cur;
  logic [N-1:0]  next_grant;

  // Search from the port after the current one, current port last.
  always_comb
  begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    next_grant = '0;
    next_cur = cur;
    if (stay && |(grant & req))
    begin
      next_grant = grant;
    end
    else
    begin
      for (int i = 1; i <= N; i++)
      begin
        idx = (int'(cur) + i) % N;
        if (!found && req[idx] && credit_ok[idx])
        begin
          found = 1'b1;
          next_grant[idx] = 1'b1;
          next_cur = IW'(idx);
        end
      end
    end
  end

  // Grant and pointer registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      grant <= '0;
      cur <= IW'(N - 1);
    end
    else
    begin
      grant <= next_grant;
      cur <= next_cur;
    end
  end

endmodule

// ==== rtl/svc_regs.sv ====
// Vendor configuration register bank of an upstream switch port.
`timescale 1ns/1ns
module svc_regs #(
  parameter int LEN_W = 12,
  parameter int PORTS = 3
)
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rd,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire logic [31:0]          cfg_wdata,
  output logic [31:0]               cfg_rdata,
  output logic                      cfg_rvalid,
  input  wire logic                 load_wr,
  input  wire logic [7:0]           load_addr,
  input  wire logic [31:0]          load_data,
  input  wire svc_pkg::svc_width_e  link_width,
  input  wire logic [2:0]           max_payload,
  input  wire logic [LEN_W-1:0]     pkt_len,
  output logic [LEN_W-1:0]          ct_start,
  input  wire logic [PORTS-1:0]     arb_req,
  input  wire logic [PORTS-1:0]     arb_credit_ok,
  output logic [PORTS-1:0]          arb_grant,
  output logic                      store_forward,
  output logic [1:0]                ct_threshold,
  output logic                      arb_stay,
  output logic                      credit_all_types,
  output logic                      egress_ordering,
  output logic                      pm_cap_disable,
  output logic                      msi_cap_disable,
  output logic                      vga_decode,
  output logic [11:0]               replay_timeout,
  output logic [13:0]               ack_latency
);

  import svc_pkg::*;

  logic [31:0] scr0;
  logic [31:0] scr1;
  logic [31:0] timer;
  logic [31:0] mode;
  logic        vga;
  logic [31:0] next_rdata;
  logic [LEN_W-1:0] next_ct_start;

  // Merges byte lanes of new data over old data, within a writable mask.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~(lanes & mask)) | (wd & lanes & mask);
  endfunction

  // Decodes a dword address, ignoring the two byte bits.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  // Scratch zero; auto-load takes priority over a software write.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      scr0 <= SVC_SCR0_RST;
    else if (load_wr && hit(load_addr, SVC_OFF_SCR0))
      scr0 <= load_data;
    else if (cfg_wr && hit(cfg_addr, SVC_OFF_SCR0))
      scr0 <= merge(scr0, cfg_wdata, cfg_be, 32'hffff_ffff);
  end

  // Scratch one.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      scr1 <= SVC_SCR1_RST;
    else if (load_wr && hit(load_addr, SVC_OFF_SCR1))
      scr1 <= load_data;
    else if (cfg_wr && hit(cfg_addr, SVC_OFF_SCR1))
      scr1 <= merge(scr1, cfg_wdata, cfg_be, 32'hffff_ffff);
  end

  // Timer overrides; capability-hide bits change only by auto-load.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer <= SVC_TIMER_RST;
    else if (load_wr && hit(load_addr, SVC_OFF_TIMER))
      timer <= load_data & SVC_TIMER_LD_MASK;
    else if (cfg_wr && hit(cfg_addr, SVC_OFF_TIMER))
      timer <= merge(timer, cfg_wdata, cfg_be, SVC_TIMER_SW_MASK);
  end

  // Video decode bit is fixed after reset and never written.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      vga <= SVC_VGA_RST;
    else
      vga <= SVC_VGA_RST;
  end

  // Switch operation mode.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode <= SVC_MODE_RST;
    else if (load_wr && hit(load_addr, SVC_OFF_MODE))
      mode <= load_data & SVC_MODE_MASK;
    else if (cfg_wr && hit(cfg_addr, SVC_OFF_MODE))
      mode <= merge(mode, cfg_wdata, cfg_be, SVC_MODE_MASK);
  end

  // Read multiplexer; unmapped offsets and reserved bits read zero.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit(cfg_addr, SVC_OFF_CAP))
      next_rdata = {SVC_CAP_LEN, SVC_CAP_NEXT, SVC_CAP_ID};
    else if (hit(cfg_addr, SVC_OFF_SCR0))
      next_rdata = scr0;
    else if (hit(cfg_addr, SVC_OFF_SCR1))
      next_rdata = scr1;
    else if (hit(cfg_addr, SVC_OFF_TIMER))
    begin
      next_rdata = timer & SVC_TIMER_LD_MASK;
      next_rdata[SVC_VGA_BIT] = vga;
    end
    else if (hit(cfg_addr, SVC_OFF_MODE))
      next_rdata = mode & SVC_MODE_MASK;
  end

  // Read answer registered one cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd;
      if (cfg_rd)
        cfg_rdata <= next_rdata;
    end
  end

  // Field outputs taken straight from the register bits.
  always_comb
  begin
    store_forward = mode[SVC_SF_BIT];
    ct_threshold = mode[SVC_CT_LSB +: 2];
    arb_stay = mode[SVC_ARB_BIT];
    credit_all_types = mode[SVC_CREDIT_BIT];
    egress_ordering = mode[SVC_EGRESS_BIT];
    pm_cap_disable = timer[SVC_PM_DIS_BIT];
    msi_cap_disable = timer[SVC_MSI_DIS_BIT];
    vga_decode = vga;
  end

  // Cut-through start: half the packet less the code, floored at zero.
  always_comb
  begin
    logic [LEN_W-1:0] half;
    logic [LEN_W-1:0] lead;
    half = pkt_len >> 1;
    lead = LEN_W'(mode[SVC_CT_LSB +: 2]);
    if (half > lead)
      next_ct_start = half - lead;
    else
      next_ct_start = '0;
  end

  // Cut-through start register; zero in store-and-forward mode.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ct_start <= '0;
    else if (mode[SVC_SF_BIT])
      ct_start <= '0;
    else
      ct_start <= next_ct_start;
  end

  // Effective link-layer timer values.
  svc_link_timers svc_link_timers_inst (
    .clk            (clk),
    .rst_n          (rst_n),
    .link_width     (link_width),
    .max_payload    (max_payload),
    .rpl_user_en    (timer[SVC_RPL_EN_BIT]),
    .rpl_user       (timer[SVC_RPL_LSB +: SVC_RPL_W]),
    .ack_user_en    (timer[SVC_ACK_EN_BIT]),
    .ack_user       (timer[SVC_ACK_LSB +: SVC_ACK_W]),
    .replay_timeout (replay_timeout),
    .ack_latency    (ack_latency)
  );

  // Egress port arbiter steered by the arbitration mode bit.
  svc_rr_arb #(
    .N (PORTS)
  ) svc_rr_arb_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .stay      (mode[SVC_ARB_BIT]),
    .req       (arb_req),
    .credit_ok (arb_credit_ok),
    .grant     (arb_grant)
  );

endmodule

// ==== sim/svc_regs_chk.sv ====
// Concurrent checks on the ports of the vendor register bank.
`timescale 1ns/1ns
module svc_regs_chk #(
  parameter int LEN_W = 12,
  parameter int PORTS = 3
)
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             cfg_wr,
  input wire logic             cfg_rd,
  input wire logic [7:0]       cfg_addr,
  input wire logic [3:0]       cfg_be,
  input wire logic [31:0]      cfg_wdata,
  input wire logic [31:0]      cfg_rdata,
  input wire logic             load_wr,
  input wire logic [7:0]       load_addr,
  input wire logic [31:0]      load_data,
  input wire logic [LEN_W-1:0] pkt_len,
  input wire logic [LEN_W-1:0] ct_start,
  input wire logic [PORTS-1:0] arb_req,
  input wire logic [PORTS-1:0] arb_credit_ok,
  input wire logic [PORTS-1:0] arb_grant,
  input wire logic             store_forward,
  input wire logic [1:0]       ct_threshold,
  input wire logic             arb_stay,
  input wire logic             credit_all_types,
  input wire logic             egress_ordering,
  input wire logic             pm_cap_disable,
  input wire logic             msi_cap_disable,
  input wire logic             vga_decode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Decoded accesses and the expected cut-through start point.
  logic             cap_rd;
  logic             tmr_rd;
  logic             mode_wr;
  logic [LEN_W-1:0] half;
  logic [LEN_W-1:0] ct_exp;
  logic [PORTS-1:0] arb_ok;
  assign arb_ok  = arb_req & arb_credit_ok;
  assign cap_rd  = cfg_rd && cfg_addr[7:2] == 6'h19;
  assign tmr_rd  = cfg_rd && cfg_addr[7:2] == 6'h1c;
  assign mode_wr = cfg_wr && cfg_addr[7:2] == 6'h1d && cfg_be[0] && !load_wr;
  assign half    = pkt_len >> 1;
  assign ct_exp  = store_forward ? '0 :
                   (half > ct_threshold ? half - ct_threshold : '0);
  AST_CAP_ID:
    assert property (cap_rd |=> cfg_rdata[7:0] == 8'h09)
      else $error("Capability identifier wrong.");
  AST_CAP_NEXT:
    assert property (cap_rd |=> cfg_rdata[15:8] == 8'hb0)
      else $error("Capability pointer wrong.");
  AST_CAP_LEN:
    assert property (cap_rd |=> cfg_rdata[31:16] == 16'h0034)
      else $error("Capability length wrong.");
  AST_TMR_TOP:
    assert property (tmr_rd |=> cfg_rdata[31] && !cfg_rdata[15])
      else $error("Timer register fixed bits wrong.");
  AST_HIDE_HOLD:
    assert property (cfg_wr && cfg_addr[7:2] == 6'h1c && !load_wr |=>
      $stable(pm_cap_disable) && $stable(msi_cap_disable))
      else $error("Hide bits changed by a config write.");
  AST_LOAD_HIDE:
    assert property (load_wr && load_addr[7:2] == 6'h1c |=>
      pm_cap_disable == $past(load_data[13]) &&
      msi_cap_disable == $past(load_data[14]))
      else $error("Loaded hide bits not taken.");
  AST_SF_WR:
    assert property (mode_wr |=> store_forward == $past(cfg_wdata[0]))
      else $error("Store forward bit not written.");
  AST_CREDIT_WR:
    assert property (mode_wr |=> credit_all_types == $past(cfg_wdata[4]))
      else $error("Credit update bit not written.");
  AST_EGRESS_WR:
    assert property (mode_wr |=> egress_ordering == $past(cfg_wdata[5]))
      else $error("Egress ordering bit not written.");
  AST_CT_START:
    assert property ($past(rst_n) |-> ct_start == $past(ct_exp))
      else $error("Cut-through start point wrong.");
  AST_MODE_RST:
    assert property ($rose(rst_n) |-> ct_threshold == 2'b01 &&
      !store_forward && !arb_stay)
      else $error("Mode reset values wrong.");
  AST_ARB_STAY:
    assert property (arb_stay && (arb_grant & arb_req) != '0 |=>
      arb_grant == $past(arb_grant))
      else $error("Sticky arbiter left its port.");
  AST_ARB_CREDIT:
    assert property (!arb_stay |=>
      (arb_grant & ~$past(arb_ok)) == '0 &&
      $onehot0(arb_grant))
      else $error("Grant given without request and credit.");
  // Main scenarios reached.
  cover property (cap_rd);
  cover property (load_wr && load_addr[7:2] == 6'h1c);
  cover property (arb_stay && (arb_grant & ~arb_credit_ok) != '0);
endmodule
bind svc_regs svc_regs_chk #(.LEN_W(LEN_W), .PORTS(PORTS)) svc_regs_chk_inst (
  .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .load_wr(load_wr), .load_addr(load_addr),
  .load_data(load_data), .pkt_len(pkt_len), .ct_start(ct_start),
  .arb_req(arb_req), .arb_credit_ok(arb_credit_ok), .arb_grant(arb_grant),
  .store_forward(store_forward), .ct_threshold(ct_threshold),
  .arb_stay(arb_stay), .credit_all_types(credit_all_types),
  .egress_ordering(egress_ordering), .pm_cap_disable(pm_cap_disable),
  .msi_cap_disable(msi_cap_disable), .vga_decode(vga_decode));

// ==== sim/svc_regs_test.sv ====
// Self-checking bench for the vendor configuration register bank.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module svc_regs_test;
  import svc_pkg::*;
  logic        clk, rst_n, cfg_wr, cfg_rd, load_wr, cfg_rvalid;
  logic        store_forward, arb_stay, credit_all_types, egress_ordering;
  logic        pm_cap_disable, msi_cap_disable, vga_decode;
  logic [7:0]  cfg_addr, load_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, load_data;
  svc_width_e  link_width;
  logic [2:0]  max_payload, arb_req, arb_credit_ok, arb_grant;
  logic [11:0] pkt_len, ct_start, replay_timeout;
  logic [13:0] ack_latency;
  logic [1:0]  ct_threshold;
  int          error_cnt, check_count, cycles;
  svc_regs #(.LEN_W(12), .PORTS(3)) svc_regs_inst (
    .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .load_wr(load_wr),
    .load_addr(load_addr), .load_data(load_data), .link_width(link_width),
    .max_payload(max_payload), .pkt_len(pkt_len), .ct_start(ct_start),
    .arb_req(arb_req), .arb_credit_ok(arb_credit_ok), .arb_grant(arb_grant),
    .store_forward(store_forward), .ct_threshold(ct_threshold),
    .arb_stay(arb_stay), .credit_all_types(credit_all_types),
    .egress_ordering(egress_ordering), .pm_cap_disable(pm_cap_disable),
    .msi_cap_disable(msi_cap_disable), .vga_decode(vga_decode),
    .replay_timeout(replay_timeout), .ack_latency(ack_latency));
  // Free-running 100 MHz clock.
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      end_of_test();
    end
  end
  // Waits for the next falling edge, where inputs change.
  task automatic tick();
    @(negedge clk);
  endtask
  // One config write pulse.
  task automatic cw(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    @(negedge clk);
    cfg_wr = 1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  // One auto-load write pulse.
  task automatic lw(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    load_wr = 1;
    load_addr = a;
    load_data = d;
    @(negedge clk);
    load_wr = 0;
  endtask
  // One config read, compared while the answer stands.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    cfg_rd = 1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 0;
    `CHK("rvalid", 1'b1, cfg_rvalid)
    `CHK("rdata", e, cfg_rdata)
  endtask
  // Main sequence of accesses and expectations.
  initial
  begin
    rst_n = 0;
    {cfg_wr, cfg_rd, load_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
    {load_addr, load_data, arb_req, arb_credit_ok} = '0;
    link_width = SVC_W_X2;
    max_payload = 3'h1;
    pkt_len = 12'h064;
    repeat (20) tick();
    rst_n = 1;
    `CHK("ct_threshold", 2'h1, ct_threshold)
    `CHK("vga_decode", 1'b1, vga_decode)
    rd(8'h64, 32'h0034_b009);
    tick();
    `CHK("rvalid_idle", 1'b0, cfg_rvalid)
    `CHK("rdata_hold", 32'h0034_b009, cfg_rdata)
    rd(8'h68, 32'h0400_1060);
    rd(8'h6c, 32'h0000_0800);
    rd(8'h70, 32'h8000_0000);
    rd(8'h74, 32'h0000_0002);
    rd(8'h80, 32'h0000_0000);
    cw(8'h80, 4'hf, 32'hffff_ffff);
    rd(8'h80, 32'h0000_0000);
    `CHK("replay", 12'h0c0, replay_timeout)
    `CHK("ack", 14'h0030, ack_latency)
    cw(8'h64, 4'hf, 32'h0000_0000);
    rd(8'h64, 32'h0034_b009);
    cw(8'h68, 4'h5, 32'haabb_ccdd);
    rd(8'h68, 32'h04bb_10dd);
    cw(8'h6c, 4'hf, 32'h1234_5678);
    rd(8'h6c, 32'h1234_5678);
    // Load and config write to one register in one cycle: load wins.
    tick();
    cfg_wr = 1;
    cfg_addr = 8'h68;
    cfg_be = 4'hf;
    cfg_wdata = 32'h1111_1111;
    load_wr = 1;
    load_addr = 8'h68;
    load_data = 32'h2222_2222;
    tick();
    cfg_wr = 0;
    load_wr = 0;
    rd(8'h68, 32'h2222_2222);
    cw(8'h70, 4'hf, 32'h4123_1456);
    tick();
    `CHK("replay", 12'h456, replay_timeout)
    `CHK("ack", 14'h0123, ack_latency)
    rd(8'h70, 32'hc123_1456);
    cw(8'h70, 4'hf, 32'hffff_ffff);
    rd(8'h70, 32'hffff_1fff);
    `CHK("pm_dis", 1'b0, pm_cap_disable)
    lw(8'h70, 32'hffff_ffff);
    `CHK("msi_dis", 1'b1, msi_cap_disable)
    rd(8'h70, 32'hffff_7fff);
    lw(8'h70, 32'h0000_0000);
    tick();
    `CHK("replay", 12'h0c0, replay_timeout)
    `CHK("ack", 14'h0030, ack_latency)
    // Built-in values for the other link widths, payload code 3.
    link_width = SVC_W_X4;
    max_payload = 3'h3;
    tick();
    `CHK("replay_x4", 12'h0a0, replay_timeout)
    `CHK("ack_x4", 14'h0028, ack_latency)
    link_width = SVC_W_X1;
    tick();
    `CHK("replay_x1", 12'h280, replay_timeout)
    `CHK("ack_x1", 14'h00a0, ack_latency)
    link_width = SVC_W_RSVD;
    tick();
    `CHK("replay_w3", 12'h050, replay_timeout)
    `CHK("ack_w3", 14'h0014, ack_latency)
    for (int c = 0; c < 4; c++)
    begin
      cw(8'h74, 4'h1, 32'(c << 1));
      tick();
      `CHK("ct_start", 12'(50 - c), ct_start)
    end
    cw(8'h74, 4'h1, 32'h0000_0001);
    `CHK("store_fwd", 1'b1, store_forward)
    tick();
    `CHK("ct_start", 12'h000, ct_start)
    lw(8'h74, 32'hffff_ffff);
    rd(8'h74, 32'h0000_003f);
    `CHK("ct_threshold", 2'h3, ct_threshold)
    `CHK("arb_stay", 1'b1, arb_stay)
    cw(8'h74, 4'hf, 32'hffff_fff0);
    `CHK("credit_all", 1'b1, credit_all_types)
    `CHK("egress_ord", 1'b1, egress_ordering)
    rd(8'h74, 32'h0000_0030);
    arb_req = 3'h3;
    arb_credit_ok = 3'h2;
    tick();
    `CHK("grant", 3'h2, arb_grant)
    arb_credit_ok = 3'h7;
    tick();
    `CHK("grant", 3'h1, arb_grant)
    arb_req = 3'h2;
    tick();
    cw(8'h74, 4'h1, 32'h0000_0008);
    `CHK("arb_stay", 1'b1, arb_stay)
    arb_credit_ok = 3'h0;
    tick();
    tick();
    `CHK("grant", 3'h2, arb_grant)
    cw(8'h74, 4'h1, 32'h0000_0000);
    tick();
    `CHK("grant", 3'h0, arb_grant)
    // Second reset in mid-run brings back every reset value.
    rst_n = 0;
    repeat (2) tick();
    rst_n = 1;
    `CHK("ct_threshold", 2'h1, ct_threshold)
    rd(8'h68, 32'h0400_1060);
    rd(8'h6c, 32'h0000_0800);
    rd(8'h70, 32'h8000_0000);
    rd(8'h74, 32'h0000_0002);
    end_of_test();
  end
endmodule
